// file: common/period_timer_pkg.sv
// Constants, register map and field layout of the 8-bit period timer.
//----------------------------------------------------------------------
// Behaviour
// - Count clock is the instruction clock (system clock over four) through prescaler.
// - Eight-bit counter starts at zero and steps once per prescaled tick while running.
// - Prescale select 00/01/10/11 divides by 1/4/16/64.
// - Counter is compared with period every cycle; equality asserts match.
// - Match reloads counter to zero on next count and steps the postscaler.
// - Counter and period registers are readable and writable at any time.
// - Reset clears the counter and sets the period to all ones.
// - Counter write, control write and reset clear prescaler and postscaler.
// - Control write leaves the counter value unchanged.
// - Four-bit postscaler counts matches and sets the latched match flag.
// - Output divide field n gives one flag per n+1 matches.
// - Request match_irq only while enable bit and match flag are both set, one clock late; irq follows masked status.
// - Unscaled match goes to the capture/compare unit as PWM time base.
// - Timer output is offered as selectable serial port shift clock.
// - In sleep the timer does not count; counter and period keep values.
// - Control bit 2 switches the timer on when set, off when clear.
// - Control bit 7 is unimplemented and reads as zero.
//----------------------------------------------------------------------
package period_timer_pkg;

  localparam int ADDR_W = 3;

  // Register indices.
  localparam logic [2:0] OFS_CONTROL    = 3'h0;
  localparam logic [2:0] OFS_COUNT      = 3'h1;
  localparam logic [2:0] OFS_PERIOD     = 3'h2;
  localparam logic [2:0] OFS_IRQ_FLAG   = 3'h3;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h4;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK   = 3'h6;

  // Control field positions.
  localparam int CKPS_LSB  = 0;
  localparam int RUN_BIT   = 2;
  localparam int OUTPS_LSB = 3;

  // Reset values and control write mask.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hff;
  localparam logic [6:0] CONTROL_MASK  = 7'h7f;

  // Instruction clock is the system clock divided by four.
  localparam int INSTR_DIV = 4;

  // Prescaler terminal counts for divide by 1, 4, 16 and 64.
  localparam logic [5:0] PRESCALE_TOP_1  = 6'h00;
  localparam logic [5:0] PRESCALE_TOP_4  = 6'h03;
  localparam logic [5:0] PRESCALE_TOP_16 = 6'h0f;
  localparam logic [5:0] PRESCALE_TOP_64 = 6'h3f;

  // Status bits for the sticky event register.
  localparam int EV_MATCH = 0;
  localparam int EV_FLAG  = 1;
  localparam int EV_W     = 2;

endpackage

// file: logic/period_timer_8bit.sv
// Eight-bit period timer with prescaler, postscaler and register port.
`timescale 1ns/10ps
`default_nettype none

module period_timer_8bit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Power state
  input  wire logic       sleep,
  // Register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       write,
  input  wire logic       read,
  output var  logic [7:0] rdata,
  // Outputs to other units
  output var  logic       pwm_time_base,
  output var  logic       shift_clock,
  output var  logic       match_irq,
  output var  logic       irq
);

  //--------------------------------------------------------------------
  // Registers and decode
  //--------------------------------------------------------------------
  logic [6:0] timer_control;
  logic [7:0] timer_count_value;
  logic [7:0] period_value;
  logic       match_flag;
  logic       match_irq_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] instr_div;
  logic [5:0] prescale_cnt;
  logic [3:0] postscale_cnt;
  logic       shift_toggle;
  logic       prev_flag;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    hit = (a == o);
  endfunction

  logic wr_control;
  logic wr_count;
  logic instr_tick;
  logic count_tick;
  logic match;
  logic [5:0] prescale_top;
  logic [1:0] events;

  assign wr_control = write && hit(addr, period_timer_pkg::OFS_CONTROL);
  assign wr_count   = write && hit(addr, period_timer_pkg::OFS_COUNT);

  assign instr_tick = (instr_div == 2'(period_timer_pkg::INSTR_DIV - 1)) && !sleep;

  always_comb begin
    case (timer_control[period_timer_pkg::CKPS_LSB +: 2])
      2'b00:   prescale_top = period_timer_pkg::PRESCALE_TOP_1;
      2'b01:   prescale_top = period_timer_pkg::PRESCALE_TOP_4;
      2'b10:   prescale_top = period_timer_pkg::PRESCALE_TOP_16;
      default: prescale_top = period_timer_pkg::PRESCALE_TOP_64;
    endcase
  end

  // run bit gates counting
  // A control or counter write in the same cycle wins over the tick, so a stale tick never disturbs
  // a freshly written count or the scalers that the write has just restarted.
  assign count_tick = instr_tick && timer_control[period_timer_pkg::RUN_BIT]
                      && (prescale_cnt == prescale_top) && !wr_control && !wr_count;

  assign match = (timer_count_value == period_value);

  //--------------------------------------------------------------------
  // Instruction clock divider
  //--------------------------------------------------------------------
  // sleep freezes the divider and so all counting
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_div <= 2'h0;
    end else if (!sleep) begin
      instr_div <= instr_div + 2'h1;
    end
  end

  //--------------------------------------------------------------------
  // Prescaler
  //--------------------------------------------------------------------
  // scaler clear on control and counter writes and reset
  always_ff @(posedge clk) begin
    if (reset || wr_control || wr_count) begin
      prescale_cnt <= 6'h00;
    end else if (instr_tick && timer_control[period_timer_pkg::RUN_BIT]) begin
      prescale_cnt <= (prescale_cnt == prescale_top) ? 6'h00 : prescale_cnt + 6'h01;
    end
  end

  //--------------------------------------------------------------------
  // Counter
  //--------------------------------------------------------------------
  // reset value, control write keeps count
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_count_value <= period_timer_pkg::COUNT_RESET;
    end else if (wr_count) begin
      timer_count_value <= wdata;
    end else if (count_tick) begin
      timer_count_value <= match ? 8'h00 : timer_count_value + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      period_value <= period_timer_pkg::PERIOD_RESET;
    end else if (write && hit(addr, period_timer_pkg::OFS_PERIOD)) begin
      period_value <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_control <= period_timer_pkg::CONTROL_RESET[6:0];
    end else if (wr_control) begin
      timer_control <= wdata[6:0] & period_timer_pkg::CONTROL_MASK;
    end
  end

  //--------------------------------------------------------------------
  // Postscaler and match flag
  //--------------------------------------------------------------------
  logic post_done;
  assign post_done = count_tick && match
                     && (postscale_cnt == timer_control[period_timer_pkg::OUTPS_LSB +: 4]);

  always_ff @(posedge clk) begin
    if (reset || wr_control || wr_count) begin
      postscale_cnt <= 4'h0;
    end else if (count_tick && match) begin
      postscale_cnt <= post_done ? 4'h0 : postscale_cnt + 4'h1;
    end
  end

  // flag held until software writes zero; a set wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      match_flag <= 1'b0;
    end else if (post_done) begin
      match_flag <= 1'b1;
    end else if (write && hit(addr, period_timer_pkg::OFS_IRQ_FLAG)) begin
      match_flag <= wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_irq_enable <= 1'b0;
    end else if (write && hit(addr, period_timer_pkg::OFS_IRQ_ENABLE)) begin
      match_irq_enable <= wdata[0];
    end
  end

  //--------------------------------------------------------------------
  // Outputs to other units
  //--------------------------------------------------------------------
  // unscaled match pulse, shift clock toggles per match
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_time_base <= 1'b0;
      shift_toggle  <= 1'b0;
    end else begin
      pwm_time_base <= count_tick && match;
      if (count_tick && match) begin
        shift_toggle <= !shift_toggle;
      end
    end
  end

  assign shift_clock = shift_toggle;

  always_ff @(posedge clk) begin
    if (reset) begin
      match_irq <= 1'b0;
    end else begin
      match_irq <= match_flag && match_irq_enable;
    end
  end

  //--------------------------------------------------------------------
  // Sticky event status and interrupt line
  //--------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_flag <= 1'b0;
    end else begin
      prev_flag <= match_flag;
    end
  end

  assign events = {match_flag && !prev_flag, count_tick && match};

  // A read clears the status, but an event in the same cycle survives.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= 2'b00;
    end else if (read && hit(addr, period_timer_pkg::OFS_IRQ_STATUS)) begin
      irq_status <= events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask <= 2'b00;
    end else if (write && hit(addr, period_timer_pkg::OFS_IRQ_MASK)) begin
      irq_mask <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status | events) & irq_mask);
    end
  end

  //--------------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------------
  // bit 7 reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (read) begin
      if (hit(addr, period_timer_pkg::OFS_CONTROL)) begin
        rdata <= {1'b0, timer_control};
      end else if (hit(addr, period_timer_pkg::OFS_COUNT)) begin
        rdata <= timer_count_value;
      end else if (hit(addr, period_timer_pkg::OFS_PERIOD)) begin
        rdata <= period_value;
      end else if (hit(addr, period_timer_pkg::OFS_IRQ_FLAG)) begin
        rdata <= {7'h00, match_flag};
      end else if (hit(addr, period_timer_pkg::OFS_IRQ_ENABLE)) begin
        rdata <= {7'h00, match_irq_enable};
      end else if (hit(addr, period_timer_pkg::OFS_IRQ_STATUS)) begin
        rdata <= {6'h00, irq_status};
      end else if (hit(addr, period_timer_pkg::OFS_IRQ_MASK)) begin
        rdata <= {6'h00, irq_mask};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  //--------------------------------------------------------------------
  // Checks: counter and period
  //--------------------------------------------------------------------
  // reset values
  a_reset_period: assert property (@(posedge clk)
    reset |=> period_value == period_timer_pkg::PERIOD_RESET && timer_count_value == period_timer_pkg::COUNT_RESET)
    else $error("period or counter wrong after reset");
  a_match_reload: assert property (@(posedge clk) disable iff (reset)
    count_tick && match && !wr_count |=> timer_count_value == 8'h00)
    else $error("counter not reloaded after match");
  a_count_step: assert property (@(posedge clk) disable iff (reset)
    count_tick && !match && !wr_count |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("counter did not step");
  a_count_write: assert property (@(posedge clk) disable iff (reset)
    wr_count |=> timer_count_value == $past(wdata))
    else $error("counter write not taken");
  a_period_write: assert property (@(posedge clk) disable iff (reset)
    write && hit(addr, period_timer_pkg::OFS_PERIOD) |=> period_value == $past(wdata))
    else $error("period write not taken");
  a_stop_hold: assert property (@(posedge clk) disable iff (reset)
    !timer_control[period_timer_pkg::RUN_BIT] && !write |=> $stable(timer_count_value) && $stable(prescale_cnt))
    else $error("stopped timer changed");
  a_sleep_hold: assert property (@(posedge clk) disable iff (reset)
    sleep && !write |=> $stable(timer_count_value) && $stable(period_value))
    else $error("timer changed in sleep");
  a_run_set: assert property (@(posedge clk) disable iff (reset)
    wr_control && wdata[period_timer_pkg::RUN_BIT] |=> timer_control[period_timer_pkg::RUN_BIT])
    else $error("run bit not taken");
  a_instr_rate: assert property (@(posedge clk) disable iff (reset)
    instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than one in four");

  //--------------------------------------------------------------------
  // Checks: scalers and flag
  //--------------------------------------------------------------------
  // control write keeps count
  a_ctrl_keep: assert property (@(posedge clk) disable iff (reset)
    wr_control |=> timer_count_value == $past(timer_count_value) && prescale_cnt == 6'h00 && postscale_cnt == 4'h0)
    else $error("control write disturbed counter or scalers");
  a_count_clear: assert property (@(posedge clk) disable iff (reset)
    wr_count |=> prescale_cnt == 6'h00 && postscale_cnt == 4'h0)
    else $error("counter write left scalers");
  a_prescale_bound: assert property (@(posedge clk) disable iff (reset)
    prescale_cnt <= prescale_top)
    else $error("prescaler beyond its ratio");
  a_post_ratio: assert property (@(posedge clk) disable iff (reset)
    post_done |-> postscale_cnt == timer_control[period_timer_pkg::OUTPS_LSB +: 4])
    else $error("postscaler ratio wrong");
  a_post_bound: assert property (@(posedge clk) disable iff (reset)
    postscale_cnt <= timer_control[period_timer_pkg::OUTPS_LSB +: 4])
    else $error("postscaler beyond its ratio");
  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    post_done |=> match_flag)
    else $error("flag not set at postscaler end");
  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    match_flag && !(write && hit(addr, period_timer_pkg::OFS_IRQ_FLAG)) |=> match_flag)
    else $error("flag dropped without write");

  //--------------------------------------------------------------------
  // Checks: outputs to other units
  //--------------------------------------------------------------------
  // unscaled match pulse
  a_time_base: assert property (@(posedge clk) disable iff (reset)
    count_tick && match |=> pwm_time_base)
    else $error("time base pulse missing");
  a_base_pulse: assert property (@(posedge clk) disable iff (reset)
    !(count_tick && match) |=> !pwm_time_base)
    else $error("time base pulse without match");
  a_shift_toggle: assert property (@(posedge clk) disable iff (reset)
    $changed(shift_clock) == pwm_time_base)
    else $error("shift clock out of step with matches");
  a_irq_gate: assert property (@(posedge clk) disable iff (reset)
    match_irq |-> $past(match_flag) && $past(match_irq_enable))
    else $error("request without flag and enable");
  a_irq_raise: assert property (@(posedge clk) disable iff (reset)
    match_flag && match_irq_enable |=> match_irq)
    else $error("request missing with flag and enable");

  //--------------------------------------------------------------------
  // Checks: register port and status
  //--------------------------------------------------------------------
  // bit 7 reads zero
  a_bit7_zero: assert property (@(posedge clk) disable iff (reset)
    read && hit(addr, period_timer_pkg::OFS_CONTROL) |=> rdata[7] == 1'b0)
    else $error("control bit 7 read as one");
  // Read data must be zero outside the cycle after a read strobe.
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !read |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  // A status bit may only be cleared by a status read.
  a_status_sticky: assert property (@(posedge clk) disable iff (reset)
    irq_status[0] && !(read && hit(addr, period_timer_pkg::OFS_IRQ_STATUS)) |=> irq_status[0])
    else $error("status bit lost without read");
  // An unmasked status bit must raise the interrupt line.
  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    |(irq_status & irq_mask) |=> irq)
    else $error("interrupt line low with unmasked status");

  c_match_seen: cover property (@(posedge clk) pwm_time_base);
  c_flag_set:   cover property (@(posedge clk) !match_flag ##1 match_flag);
  c_irq_raise:  cover property (@(posedge clk) match_irq);
  c_div64:      cover property (@(posedge clk) count_tick && timer_control[1:0] == 2'b11);
  c_sleep_run:  cover property (@(posedge clk) sleep && timer_control[period_timer_pkg::RUN_BIT]);

endmodule

`default_nettype wire

// file: bench/ccp_pwm_model.sv
// Capture/compare unit stand-in that counts timer time base pulses.
`timescale 1ns/10ps
`default_nettype none

module ccp_pwm_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Time base from the timer
  input  wire logic pwm_time_base,
  // Observed pulse count
  output var  int   pulses
);
  always_ff @(posedge clk) begin
    if (reset) begin
      pulses <= 0;
    end else if (pwm_time_base) begin
      pulses <= pulses + 1;
    end
  end
endmodule
`default_nettype wire

// file: bench/period_timer_8bit_tb.sv
// Self-checking testbench of the 8-bit period timer.
`timescale 1ns/10ps
`default_nettype none

module period_timer_8bit_tb;
  logic       clk;
  logic       reset;
  logic       sleep;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       write;
  logic       read;
  logic [7:0] rdata;
  logic       pwm_time_base;
  logic       shift_clock;
  logic       match_irq;
  logic       irq;
  int         pulses;
  int         fail_count;
  int         n_tests;
  int         cyc;

  period_timer_8bit u_period_timer_8bit (.clk(clk), .reset(reset), .sleep(sleep), .addr(addr), .wdata(wdata),
    .write(write), .read(read), .rdata(rdata), .pwm_time_base(pwm_time_base), .shift_clock(shift_clock),
    .match_irq(match_irq), .irq(irq));
  ccp_pwm_model u_ccp_pwm_model (.clk(clk), .reset(reset), .pwm_time_base(pwm_time_base), .pulses(pulses));

  //----------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    write <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken then.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    read <= 1'b1;
    addr <= a;
    @(posedge clk);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_pulse(output int t);
    int i;
    i = 0;
    // Step off the edge first, so a pulse launched at this edge is seen settled.
    #1;
    while (pwm_time_base !== 1'b0 && i < 2000) begin
      @(posedge clk);
      #1;
      i++;
    end
    while (pwm_time_base !== 1'b1 && i < 2000) begin
      @(posedge clk);
      #1;
      i++;
    end
    t = cyc;
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] v;
    rd(period_timer_pkg::OFS_CONTROL, v);
    chk(v, 16'h0000);
    rd(period_timer_pkg::OFS_COUNT, v);
    chk(v, 16'h0000);
    rd(period_timer_pkg::OFS_PERIOD, v);
    chk(v, 16'h00ff);
    chk(irq, 1'b0);
  endtask

  task automatic t_registers();
    logic [7:0] v;
    wr(period_timer_pkg::OFS_CONTROL, 8'hff);
    rd(period_timer_pkg::OFS_CONTROL, v);
    chk(v, 16'h007f);
    wr(3'h7, 8'h55);
    rd(3'h7, v);
    chk(v, 16'h0000);
    wr(period_timer_pkg::OFS_CONTROL, 8'h00);
  endtask

  // Spacing between pulses is 4 clocks per tick times divider times period plus one.
  task automatic t_prescale();
    int t0;
    int t1;
    logic s0;
    wr(period_timer_pkg::OFS_PERIOD, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(period_timer_pkg::OFS_CONTROL, 8'h04 | 8'(c));
      wait_pulse(t0);
      s0 = shift_clock;
      wait_pulse(t1);
      chk(16'(t1 - t0), 16'(12 * (1 << (2 * c))));
      chk(shift_clock, !s0);
    end
  endtask

  task automatic t_postscale();
    logic [7:0] v;
    int p0;
    int i;
    wr(period_timer_pkg::OFS_CONTROL, 8'h00);
    wr(period_timer_pkg::OFS_IRQ_FLAG, 8'h00);
    wr(period_timer_pkg::OFS_IRQ_ENABLE, 8'h01);
    wr(period_timer_pkg::OFS_CONTROL, 8'h14);
    p0 = pulses;
    for (i = 0; i < 200 && match_irq !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(16'(pulses - p0), 16'h0003);
    repeat (40) @(posedge clk);
    rd(period_timer_pkg::OFS_IRQ_FLAG, v);
    chk(v[0], 1'b1);
    wr(period_timer_pkg::OFS_CONTROL, 8'h00);
    wr(period_timer_pkg::OFS_IRQ_FLAG, 8'h00);
    repeat (3) @(posedge clk);
    chk(match_irq, 1'b0);
    wr(period_timer_pkg::OFS_IRQ_ENABLE, 8'h00);
    wr(period_timer_pkg::OFS_IRQ_FLAG, 8'h01);
    repeat (3) @(posedge clk);
    chk(match_irq, 1'b0);
    wr(period_timer_pkg::OFS_IRQ_ENABLE, 8'h01);
    repeat (3) @(posedge clk);
    chk(match_irq, 1'b1);
  endtask

  task automatic t_hold_and_run();
    logic [7:0] v;
    int p0;
    wr(period_timer_pkg::OFS_COUNT, 8'h05);
    wr(period_timer_pkg::OFS_CONTROL, 8'h1b);
    p0 = pulses;
    repeat (100) @(posedge clk);
    rd(period_timer_pkg::OFS_COUNT, v);
    chk(v, 16'h0005);
    chk(16'(pulses - p0), 16'h0000);
    rd(period_timer_pkg::OFS_CONTROL, v);
    chk(v, 16'h001b);
    wr(period_timer_pkg::OFS_PERIOD, 8'hff);
    wr(period_timer_pkg::OFS_COUNT, 8'h00);
    wr(period_timer_pkg::OFS_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    rd(period_timer_pkg::OFS_COUNT, v);
    chk(v >= 8'h08 && v <= 8'h0b, 1'b1);
  endtask

  task automatic t_sleep();
    logic [7:0] a;
    logic [7:0] v;
    @(posedge clk) sleep <= 1'b1;
    rd(period_timer_pkg::OFS_COUNT, a);
    repeat (50) @(posedge clk);
    rd(period_timer_pkg::OFS_COUNT, v);
    chk(v, a);
    rd(period_timer_pkg::OFS_PERIOD, v);
    chk(v, 16'h00ff);
    @(posedge clk) sleep <= 1'b0;
    repeat (20) @(posedge clk);
    rd(period_timer_pkg::OFS_COUNT, v);
    chk(v != a, 1'b1);
  endtask

  task automatic t_irq();
    logic [7:0] v;
    int i;
    wr(period_timer_pkg::OFS_PERIOD, 8'h02);
    // The counter is far above the new period; restart it so matches come at once.
    wr(period_timer_pkg::OFS_COUNT, 8'h00);
    wr(period_timer_pkg::OFS_IRQ_MASK, 8'h00);
    rd(period_timer_pkg::OFS_IRQ_STATUS, v);
    repeat (60) @(posedge clk);
    chk(irq, 1'b0);
    wr(period_timer_pkg::OFS_IRQ_MASK, 8'h01);
    for (i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
    chk(irq, 1'b1);
    wr(period_timer_pkg::OFS_CONTROL, 8'h00);
    rd(period_timer_pkg::OFS_IRQ_STATUS, v);
    chk(v, 16'h0001);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  //----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  //----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // The longest scenario needs a few thousand cycles, so this margin is wide.
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    {reset, sleep, addr, wdata, write, read} = {1'b1, 1'b0, 3'h0, 8'h00, 1'b0, 1'b0};
    {fail_count, n_tests, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_registers();
    t_prescale();
    t_postscale();
    t_hold_and_run();
    t_sleep();
    t_irq();
    wr(period_timer_pkg::OFS_CONTROL, 8'h04);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    end_of_test();
  end
endmodule
`default_nettype wire
